// >>> rtl/utbg_uart_map.vh
`ifndef UTBG_UART_MAP_VH
`define UTBG_UART_MAP_VH

// register byte offsets
`define UTBG_OFS_CTRL 8'h00
`define UTBG_OFS_DATA 8'h04
`define UTBG_OFS_TMR 8'h08
`define UTBG_OFS_RELOAD 8'h0c
`define UTBG_OFS_STAT 8'h10
`define UTBG_OFS_MASK 8'h14
`define UTBG_OFS_LOW 8'h18

// serial_control_reg fields
`define UTBG_CTL_MODE 7
`define UTBG_CTL_ONE 6
`define UTBG_CTL_MCE 5
`define UTBG_CTL_REN 4
`define UTBG_CTL_TB8 3
`define UTBG_CTL_RB8 2
`define UTBG_CTL_TI 1
`define UTBG_CTL_RI 0
`define UTBG_CTL_RESET 8'h40

// status and mask bits
`define UTBG_ST_RX 0
`define UTBG_ST_TX 1

// timer control fields
`define UTBG_TMR_RUN 0
`define UTBG_TMR_SEL_HI 3
`define UTBG_TMR_SEL_LO 1

// timer clock sources
`define UTBG_SRC_SYS 3'h0
`define UTBG_SRC_DIV4 3'h1
`define UTBG_SRC_DIV12 3'h2
`define UTBG_SRC_DIV48 3'h3
`define UTBG_SRC_OSC8 3'h4
`define UTBG_SRC_PIN 3'h5

// prescaler terminal counts
`define UTBG_PRE_LAST 6'h2f
`define UTBG_PRE_12A 6'h0b
`define UTBG_PRE_12B 6'h17
`define UTBG_PRE_12C 6'h23
`define UTBG_OSC_LAST 3'h7
`define UTBG_CNT_TOP 8'hff

// frame lengths in bit times
`define UTBG_FRAME8 4'ha
`define UTBG_FRAME9 4'hb
`define UTBG_DATA8 4'h8
`define UTBG_DATA9 4'h9

`endif

// >>> rtl/utbg_uart.v
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`include "utbg_uart_map.vh"

module utbg_uart (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // serial pins and timer sources
    input wire rxd,
    output reg txd,
    input wire ext_osc,
    input wire timer_ext_input,
    // interrupt
    output reg irq
);

    localparam TX_IDLE = 2'b01;
    localparam TX_SEND = 2'b10;
    localparam RX_IDLE = 4'b0001;
    localparam RX_START = 4'b0010;
    localparam RX_DATA = 4'b0100;
    localparam RX_STOP = 4'b1000;

    // registers
    reg [7:0] ctrl_ff;
    reg [3:0] tmr_ctl_ff;
    reg [7:0] reload_ff;
    reg [7:0] low_ff;
    reg [7:0] rx_cnt_ff;
    reg [1:0] mask_ff;
    reg [7:0] rx_latch_ff;
    reg [5:0] pre_ff;
    reg [2:0] osc_div_ff;
    reg tx_half_ff;
    reg rx_half_ff;
    reg [1:0] tx_st_ff;
    reg [10:0] tx_shift_ff;
    reg [3:0] tx_left_ff;
    reg [3:0] rx_st_ff;
    reg [8:0] rx_shift_ff;
    reg [3:0] rx_left_ff;
    reg [7:0] a_addr_ff;
    reg a_wr_ff;
    // synchronisers
    reg rxd_s1_ff, rxd_s2_ff, rxd_q_ff;
    reg osc_s1_ff, osc_s2_ff, osc_q_ff;
    reg pin_s1_ff, pin_s2_ff, pin_q_ff;

    wire mode9 = ctrl_ff[`UTBG_CTL_MODE];
    wire run = tmr_ctl_ff[`UTBG_TMR_RUN];
    wire [2:0] src_sel = tmr_ctl_ff[`UTBG_TMR_SEL_HI:`UTBG_TMR_SEL_LO];
    wire ahb_go = hsel & htrans[1] & hready;

    // write strobe for one offset in the data phase
    function wr_hit;
        input [7:0] ofs;
        begin
            wr_hit = a_wr_ff & (a_addr_ff == ofs);
        end
    endfunction

    // ahb address phase capture; unmapped writes simply match nothing
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            a_addr_ff <= 8'hff;
            a_wr_ff <= 1'b0;
        end else begin
            a_addr_ff <= ahb_go ? haddr[7:0] : 8'hff;
            a_wr_ff <= ahb_go & hwrite;
        end
    end

    // synchronise pins before any logic looks at them
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rxd_s1_ff <= 1'b1;
            rxd_s2_ff <= 1'b1;
            rxd_q_ff <= 1'b1;
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            osc_q_ff <= 1'b0;
            pin_s1_ff <= 1'b0;
            pin_s2_ff <= 1'b0;
            pin_q_ff <= 1'b0;
        end else begin
            rxd_s1_ff <= rxd;
            rxd_s2_ff <= rxd_s1_ff;
            rxd_q_ff <= rxd_s2_ff;
            osc_s1_ff <= ext_osc;
            osc_s2_ff <= osc_s1_ff;
            osc_q_ff <= osc_s2_ff;
            pin_s1_ff <= timer_ext_input;
            pin_s2_ff <= pin_s1_ff;
            pin_q_ff <= pin_s2_ff;
        end
    end

    wire osc_rise = osc_s2_ff & ~osc_q_ff;
    wire pin_fall = ~pin_s2_ff & pin_q_ff;
    wire rx_fall = ~rxd_s2_ff & rxd_q_ff;

    // prescalers; osc/8 is limited by the double sampling of the pin
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pre_ff <= 6'h00;
            osc_div_ff <= 3'h0;
        end else begin
            pre_ff <= (pre_ff == `UTBG_PRE_LAST) ? 6'h00 : pre_ff + 6'h01;
            if (osc_rise)
                osc_div_ff <= osc_div_ff + 3'h1;
        end
    end

    // timer clock source select
    reg tick;
    always @* begin
        case (src_sel)
            `UTBG_SRC_SYS: tick = 1'b1;
            `UTBG_SRC_DIV4: tick = (pre_ff[1:0] == 2'b11);
            `UTBG_SRC_DIV12: tick = (pre_ff == `UTBG_PRE_12A) | (pre_ff == `UTBG_PRE_12B) |
                (pre_ff == `UTBG_PRE_12C) | (pre_ff == `UTBG_PRE_LAST);
            `UTBG_SRC_DIV48: tick = (pre_ff == `UTBG_PRE_LAST);
            `UTBG_SRC_OSC8: tick = osc_rise & (osc_div_ff == `UTBG_OSC_LAST);
            `UTBG_SRC_PIN: tick = pin_fall;
            default: tick = 1'b0;
        endcase
    end

    wire cnt_tick = run & tick;
    wire tx_ovf = cnt_tick & (low_ff == `UTBG_CNT_TOP);
    wire rx_ovf = cnt_tick & (rx_cnt_ff == `UTBG_CNT_TOP);
    wire tx_bit = tx_ovf & tx_half_ff; // every second overflow
    wire rx_sample = rx_ovf & ~rx_half_ff;
    wire rx_arm = (rx_st_ff == RX_IDLE) & ctrl_ff[`UTBG_CTL_REN] & rx_fall;

    // transmit counter: 8-bit auto-reload, overflow every 256-reload ticks
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            low_ff <= 8'h00;
            tx_half_ff <= 1'b0;
        end else begin
            if (wr_hit(`UTBG_OFS_LOW))
                low_ff <= hwdata[7:0];
            else if (tx_ovf)
                low_ff <= reload_ff;
            else if (cnt_tick)
                low_ff <= low_ff + 8'h01;
            if (tx_ovf)
                tx_half_ff <= ~tx_half_ff;
        end
    end

    // hidden receive counter, realigned by the start edge
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_cnt_ff <= 8'h00;
            rx_half_ff <= 1'b0;
        end else begin
            if (rx_arm) begin
                rx_cnt_ff <= reload_ff;
                rx_half_ff <= 1'b0;
            end else begin
                if (rx_ovf)
                    rx_cnt_ff <= reload_ff;
                else if (cnt_tick)
                    rx_cnt_ff <= rx_cnt_ff + 8'h01;
                if (rx_ovf)
                    rx_half_ff <= ~rx_half_ff;
            end
        end
    end

    // transmitter; a write while busy is dropped so the frame stays intact
    wire tx_load = wr_hit(`UTBG_OFS_DATA) & (tx_st_ff == TX_IDLE);
    wire tx_stop_begin = (tx_st_ff == TX_SEND) & tx_bit & (tx_left_ff == 4'h1);
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_st_ff <= TX_IDLE;
            tx_shift_ff <= 11'h7ff;
            tx_left_ff <= 4'h0;
            txd <= 1'b1;
        end else begin
            case (tx_st_ff)
                TX_IDLE: begin
                    txd <= 1'b1;
                    if (tx_load) begin
                        tx_st_ff <= TX_SEND;
                        tx_shift_ff <= {1'b1, mode9 ? ctrl_ff[`UTBG_CTL_TB8] : 1'b1,
                            hwdata[7:0], 1'b0};
                        tx_left_ff <= mode9 ? `UTBG_FRAME9 : `UTBG_FRAME8;
                    end
                end
                TX_SEND: begin
                    if (tx_bit) begin
                        if (tx_left_ff == 4'h0) begin
                            tx_st_ff <= TX_IDLE; // stop bit has lasted a full bit
                        end else begin
                            txd <= tx_shift_ff[0]; // lsb first
                            tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                            tx_left_ff <= tx_left_ff - 4'h1;
                        end
                    end
                end
                default: tx_st_ff <= TX_IDLE;
            endcase
        end
    end

    // receiver runs alongside the transmitter
    wire rx_ninth = mode9 ? rx_shift_ff[8] : rxd_s2_ff;
    wire [7:0] rx_byte = mode9 ? rx_shift_ff[7:0] : rx_shift_ff[8:1];
    wire rx_accept = (rx_st_ff == RX_STOP) & rx_sample & ~ctrl_ff[`UTBG_CTL_RI] &
        (~ctrl_ff[`UTBG_CTL_MCE] | rx_ninth);
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_st_ff <= RX_IDLE;
            rx_shift_ff <= 9'h000;
            rx_left_ff <= 4'h0;
            rx_latch_ff <= 8'h00;
        end else begin
            if (rx_accept)
                rx_latch_ff <= rx_byte;
            if (~ctrl_ff[`UTBG_CTL_REN]) begin
                rx_st_ff <= RX_IDLE;
            end else begin
                case (rx_st_ff)
                    RX_IDLE: begin
                        if (rx_arm)
                            rx_st_ff <= RX_START;
                    end
                    RX_START: begin
                        if (rx_sample) begin
                            // a high line at mid start bit is a glitch
                            rx_st_ff <= rxd_s2_ff ? RX_IDLE : RX_DATA;
                            rx_left_ff <= mode9 ? `UTBG_DATA9 : `UTBG_DATA8;
                        end
                    end
                    RX_DATA: begin
                        if (rx_sample) begin
                            rx_shift_ff <= {rxd_s2_ff, rx_shift_ff[8:1]};
                            rx_left_ff <= rx_left_ff - 4'h1;
                            if (rx_left_ff == 4'h1)
                                rx_st_ff <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (rx_sample)
                            rx_st_ff <= RX_IDLE;
                    end
                    default: rx_st_ff <= RX_IDLE;
                endcase
            end
        end
    end

    // control register and sticky flags; hardware set beats clear
    wire clr_ri = wr_hit(`UTBG_OFS_STAT) & hwdata[`UTBG_ST_RX];
    wire clr_ti = wr_hit(`UTBG_OFS_STAT) & hwdata[`UTBG_ST_TX];
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= `UTBG_CTL_RESET;
            tmr_ctl_ff <= 4'h0;
            reload_ff <= 8'h00;
            mask_ff <= 2'b00;
        end else begin
            if (wr_hit(`UTBG_OFS_CTRL)) begin
                ctrl_ff[`UTBG_CTL_MODE] <= hwdata[`UTBG_CTL_MODE];
                ctrl_ff[`UTBG_CTL_MCE] <= hwdata[`UTBG_CTL_MCE];
                ctrl_ff[`UTBG_CTL_REN] <= hwdata[`UTBG_CTL_REN];
                ctrl_ff[`UTBG_CTL_TB8] <= hwdata[`UTBG_CTL_TB8];
            end
            if (rx_accept)
                ctrl_ff[`UTBG_CTL_RB8] <= rx_ninth;
            ctrl_ff[`UTBG_CTL_RI] <= rx_accept | (ctrl_ff[`UTBG_CTL_RI] & ~clr_ri);
            ctrl_ff[`UTBG_CTL_TI] <= tx_stop_begin |
                (ctrl_ff[`UTBG_CTL_TI] & ~clr_ti);
            if (wr_hit(`UTBG_OFS_TMR))
                tmr_ctl_ff <= hwdata[3:0];
            if (wr_hit(`UTBG_OFS_RELOAD))
                reload_ff <= hwdata[7:0];
            if (wr_hit(`UTBG_OFS_MASK))
                mask_ff <= hwdata[1:0];
        end
    end

    // interrupt level from unmasked flags
    always @(posedge sys_clk or posedge rst) begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= (ctrl_ff[`UTBG_CTL_RI] & mask_ff[`UTBG_ST_RX]) |
                (ctrl_ff[`UTBG_CTL_TI] & mask_ff[`UTBG_ST_TX]);
    end

    // read mux in the address phase; the data window never shows tx data
    reg [31:0] rd_mux;
    always @* begin
        case (haddr[7:0])
            `UTBG_OFS_CTRL: rd_mux = {24'h000000, ctrl_ff};
            `UTBG_OFS_DATA: rd_mux = {24'h000000, rx_latch_ff};
            `UTBG_OFS_TMR: rd_mux = {28'h0000000, tmr_ctl_ff};
            `UTBG_OFS_RELOAD: rd_mux = {24'h000000, reload_ff};
            `UTBG_OFS_STAT: rd_mux = {30'h0, ctrl_ff[`UTBG_CTL_TI],
                ctrl_ff[`UTBG_CTL_RI]};
            `UTBG_OFS_MASK: rd_mux = {30'h0, mask_ff};
            `UTBG_OFS_LOW: rd_mux = {24'h000000, low_ff};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // zero wait state slave, always okay
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (ahb_go & ~hwrite)
                hrdata <= rd_mux;
        end
    end

endmodule

// >>> verif/utbg_uart_chk.sv
`timescale 1ns/1ns
`include "utbg_uart_map.vh"
module utbg_uart_chk (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // bus side
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // serial out and interrupt
    input wire txd,
    input wire irq
);
    reg rd_ff, wr_ff;
    reg [7:0] addr_ff;
    reg [1:0] mask_ff;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // data phase shadow; mask copy lets irq be judged without peeking inside
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {rd_ff, wr_ff, addr_ff, mask_ff} <= 12'h0;
        end else begin
            rd_ff <= hsel && htrans[1] && hready && !hwrite;
            wr_ff <= hsel && htrans[1] && hready && hwrite;
            addr_ff <= haddr[7:0];
            if (wr_ff && addr_ff == `UTBG_OFS_MASK)
                mask_ff <= hwdata[1:0];
        end
    end
    sequence s_data_write;
        wr_ff && addr_ff == `UTBG_OFS_DATA;
    endsequence
    // bound assumes the timer runs from the system clock
    sequence s_start_bit;
        ##[1:520] !txd;
    endsequence
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_zero_wait: assert property (hreadyout) else $error("wait state");
    a_read_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_upper_zero: assert property (rd_ff |-> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_spare_one: assert property (rd_ff && addr_ff == `UTBG_OFS_CTRL |-> hrdata[6])
        else $error("control bit 6 reads zero");
    a_unmapped_zero: assert property (rd_ff && addr_ff > `UTBG_OFS_LOW |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_irq_masked: assert property (irq |-> $past(mask_ff) != 2'h0)
        else $error("irq with mask clear");
    a_irq_sticky: assert property (irq && !wr_ff && !$past(wr_ff) |=> irq)
        else $error("irq dropped without a write");
    a_tx_kick: assert property (s_data_write |-> s_start_bit)
        else $error("no start bit after data write");
    a_release_idle: assert property ($fell(rst) |-> txd && !irq)
        else $error("not idle after reset");
endmodule
bind utbg_uart utbg_uart_chk u_chk (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .txd(txd), .irq(irq));

// >>> verif/utbg_far_end.sv
`timescale 1ns/1ns
module utbg_far_end #(
    parameter BIT = 32
) (
    // clock
    input wire sys_clk,
    // serial lines and frame mode
    output reg line_out = 1'b1,
    input wire line_in,
    input wire mode9,
    // one-cycle report of a frame heard
    output reg got_stb = 1'b0,
    output reg [8:0] got_data = 9'h000
);
    integer tk, rk;
    reg [8:0] tx_sh, rx_sh;
    // start, data lsb first, ninth only in 9-bit mode, stop
    task send(input [7:0] d, input nine);
        tx_sh = {nine, d};
        line_out <= 1'b0;
        repeat (BIT) @(posedge sys_clk);
        for (tk = 0; tk < (mode9 ? 9 : 8); tk++) begin
            line_out <= tx_sh[tk];
            repeat (BIT) @(posedge sys_clk);
        end
        line_out <= 1'b1;
        repeat (BIT) @(posedge sys_clk);
    endtask
    // mid-bit sampling from the start edge; a bad stop is not reported
    always begin
        @(negedge line_in);
        repeat (BIT / 2) @(posedge sys_clk);
        if (!line_in) begin
            rx_sh = 9'h0;
            for (rk = 0; rk < (mode9 ? 9 : 8); rk++) begin
                repeat (BIT) @(posedge sys_clk);
                rx_sh[rk] = line_in;
            end
            repeat (BIT) @(posedge sys_clk);
            got_data <= rx_sh;
            got_stb <= line_in;
            @(posedge sys_clk);
            got_stb <= 1'b0;
        end
    end
endmodule

// >>> verif/tb_utbg_uart.sv
`timescale 1ns/1ns
`include "utbg_uart_map.vh"
module tb_utbg_uart;
    reg sys_clk, rst, hwrite, mode9;
    // free-running sources start from a known level, one driver each
    reg ext_osc = 1'b0;
    reg timer_ext_input = 1'b0;
    reg [31:0] exp_frame;
    reg [1:0] htrans;
    reg [31:0] haddr, hwdata, rd;
    reg [7:0] seed, b;
    reg [15:0] cyc = 16'h0;
    wire [31:0] hrdata;
    wire hreadyout, txd, rxd, irq, got_stb;
    wire [8:0] got_data;
    integer n_fail, tests_run, i;
    logic [8:0] exp_q[$];
    int divs[7] = '{1, 4, 12, 48, 16, 4, 0};
    utbg_uart uut (.sys_clk(sys_clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .rxd(rxd), .txd(txd), .ext_osc(ext_osc),
        .timer_ext_input(timer_ext_input), .irq(irq));
    utbg_far_end #(.BIT(32)) far (.sys_clk(sys_clk), .line_out(rxd), .line_in(txd),
        .mode9(mode9), .got_stb(got_stb), .got_data(got_data));
    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one single transfer; read data is taken at the end of the data phase
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), rd, e);
    endtask
    task finish_test;
        if (exp_q.size() != 0)
            n_fail = n_fail + 1;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // external timer sources: oscillator rises every 2 cycles, pin falls every 4
    always @(posedge sys_clk) begin
        cyc <= cyc + 16'h1;
        ext_osc <= ~ext_osc;
        if (cyc[0])
            timer_ext_input <= ~timer_ext_input;
    end
    // frames heard by the far end are matched against the oldest note
    always @(posedge sys_clk) begin
        if (got_stb === 1'b1) begin
            // a frame with no note behind it can never match
            exp_frame = exp_q.size() ? {23'h0, exp_q.pop_front()} : 32'hffffffff;
            check("tx frame", {23'h0, got_data}, exp_frame);
        end
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        n_fail = n_fail + 1;
        finish_test;
    end
    initial begin
        {rst, hwrite, mode9, htrans} = 5'h10;
        {haddr, hwdata, n_fail, tests_run} = 128'h0;
        seed = 8'h1b;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rchk(`UTBG_OFS_CTRL, 32'h40);
        rchk(`UTBG_OFS_TMR, 32'h0);
        rchk(`UTBG_OFS_RELOAD, 32'h0);
        rchk(`UTBG_OFS_MASK, 32'h0);
        rchk(`UTBG_OFS_STAT, 32'h0);
        rchk(8'h1c, 32'h0);
        // each source counted over 192 cycles; reload 0 wraps the count at 256
        for (i = 0; i < 7; i++) begin
            xfer(1'b1, `UTBG_OFS_TMR, (i << 1) | 1);
            xfer(1'b0, `UTBG_OFS_LOW, 32'h0);
            b = rd[7:0];
            repeat (189) @(posedge sys_clk);
            xfer(1'b0, `UTBG_OFS_LOW, 32'h0);
            check("low ticks", 8'(rd[7:0] - b), divs[i] ? 192 / divs[i] : 0);
        end
        xfer(1'b1, `UTBG_OFS_TMR, 32'h1);
        xfer(1'b1, `UTBG_OFS_RELOAD, 32'hf0); // bit time 32 cycles
        // restart the count so the first overflow is near, not up to 256 ticks away
        xfer(1'b1, `UTBG_OFS_LOW, 32'hf0);
        xfer(1'b1, `UTBG_OFS_MASK, 32'h3);
        xfer(1'b1, `UTBG_OFS_CTRL, 32'h10);
        seed = lfsr(seed);
        exp_q.push_back({1'b0, seed});
        xfer(1'b1, `UTBG_OFS_DATA, {24'h0, seed});
        repeat (seed[3:0]) @(posedge sys_clk);
        far.send(seed ^ 8'h5a, 1'b0);
        repeat (40) @(posedge sys_clk);
        rchk(`UTBG_OFS_STAT, 32'h3);
        check("irq", {31'h0, irq}, 32'h1);
        rchk(`UTBG_OFS_DATA, {24'h0, seed ^ 8'h5a});
        rchk(`UTBG_OFS_CTRL, 32'h57);
        far.send(~seed, 1'b0);
        repeat (8) @(posedge sys_clk);
        rchk(`UTBG_OFS_DATA, {24'h0, seed ^ 8'h5a});
        xfer(1'b1, `UTBG_OFS_STAT, 32'h3);
        repeat (2) @(posedge sys_clk);
        check("irq", {31'h0, irq}, 32'h0);
        seed = lfsr(seed);
        far.send(seed, 1'b0);
        fork
            far.send(~seed, 1'b0);
            begin
                repeat (100) @(posedge sys_clk);
                rchk(`UTBG_OFS_DATA, {24'h0, seed});
                xfer(1'b1, `UTBG_OFS_STAT, 32'h1);
            end
        join
        repeat (8) @(posedge sys_clk);
        rchk(`UTBG_OFS_DATA, {24'h0, ~seed});
        xfer(1'b1, `UTBG_OFS_STAT, 32'h3);
        xfer(1'b1, `UTBG_OFS_CTRL, 32'hb8);
        mode9 <= 1'b1;
        seed = lfsr(seed);
        exp_q.push_back({1'b1, seed});
        xfer(1'b1, `UTBG_OFS_DATA, {24'h0, seed});
        far.send(~seed, 1'b0);
        repeat (40) @(posedge sys_clk);
        rchk(`UTBG_OFS_STAT, 32'h2);
        far.send(seed ^ 8'h33, 1'b1);
        repeat (8) @(posedge sys_clk);
        rchk(`UTBG_OFS_CTRL, 32'hff);
        rchk(`UTBG_OFS_DATA, {24'h0, seed ^ 8'h33});
        xfer(1'b1, `UTBG_OFS_MASK, 32'h0);
        repeat (2) @(posedge sys_clk);
        check("irq", {31'h0, irq}, 32'h0);
        xfer(1'b1, `UTBG_OFS_MASK, 32'h2);
        repeat (2) @(posedge sys_clk);
        check("irq", {31'h0, irq}, 32'h1);
        finish_test;
    end
endmodule
